/* pin_ctrl_model.sv */
// controller model driving the latch pins
`timescale 1ns/100ps
`default_nettype none
module pin_ctrl_model
(
   // clock
   input wire logic i_core_clk,
   // pins toward the latch
   output var sipo_latch_pkg::ctrl_pins_t o_pins
);
   import sipo_latch_pkg::*;
   // idle levels before reset release
   task automatic idle();
      o_pins = PIN_IDLE;
   endtask
   task automatic levels(input logic oe_n, input logic clear_n);
      o_pins.out_enable_n = oe_n;
      o_pins.shift_clear_n = clear_n;
   endtask
   task automatic hold();
      repeat (6) @(negedge i_core_clk);
   endtask
   // rise then fall, clocks optionally tied
   task automatic pulse(input logic sh, input logic st, input logic d);
      o_pins.serial_in = d;
      hold();
      o_pins.shift_clock = sh;
      o_pins.store_clock = st;
      hold();
      o_pins.shift_clock = 1'b0;
      o_pins.store_clock = 1'b0;
      o_pins.serial_in = ~d;
      hold();
   endtask
endmodule
`default_nettype wire

/* pin_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module pin_sync
#(
   parameter logic INIT_LEVEL = 1'b0
)
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst_n,
   // pin side
   input wire logic i_pin,
   // filtered level
   output logic o_level
);
   logic [2:0] sync_reg;
   logic [2:0] sync_next;
   logic level_reg;
   logic level_next;

   always_comb
   begin
      sync_next = {sync_reg[1:0], i_pin};
      level_next = level_reg;
      // later stages agree
      if (sync_reg[1] == sync_reg[2])
      begin
         level_next = sync_reg[2];
      end
   end

   always_ff @(posedge i_core_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync_reg <= {3{INIT_LEVEL}};
         level_reg <= INIT_LEVEL;
      end
      else
      begin
         sync_reg <= sync_next;
         level_reg <= level_next;
      end
   end

   assign o_level = level_reg;
endmodule
`default_nettype wire

/* serial_in_parallel_out_latch_tb_top.sv */
// self-checking bench for the serial latch
`timescale 1ns/100ps
`default_nettype none
module serial_in_parallel_out_latch_tb_top;
   import sipo_latch_pkg::*;
   logic core_clk;
   logic reset_n;
   ctrl_pins_t pins;
   logic [7:0] par_out;
   logic [7:0] oe_n;
   logic cascade;
   logic [7:0] stages;
   logic [7:0] store;
   logic [31:0] seed;
   int n_errors;
   int n_checks;
   sipo_latch i_dut (.i_core_clk(core_clk), .i_reset_n(reset_n), .i_pins(pins),
      .o_par_out(par_out), .o_par_out_oe_n(oe_n), .o_cascade_out(cascade));
   pin_ctrl_model i_ctrl (.i_core_clk(core_clk), .o_pins(pins));
   initial
   begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end
   function automatic logic [31:0] xorshift(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [7:0] shift_in(input logic [7:0] s, input logic d);
      return {s[6:0], d};
   endfunction
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_errors++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic verify(input logic oe);
      check("oe_n", oe ? 8'hFF : 8'h00, oe_n);
      if (!oe) check("par_out", store, par_out);
      check("cascade", {7'h00, stages[7]}, {7'h00, cascade});
   endtask
   task automatic step(input logic sh, input logic st, input logic d);
      i_ctrl.pulse(sh, st, d);
      if (st) store = stages;
      if (sh) stages = shift_in(stages, d);
   endtask
   task automatic finish_test();
      if (n_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial
   begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      finish_test();
   end
   initial
   begin
      n_errors = 0;
      n_checks = 0;
      seed = 32'hC065A487;
      stages = 8'h00;
      store = 8'h00;
      i_ctrl.idle();
      reset_n = 1'b0;
      repeat (5) @(negedge core_clk);
      reset_n = 1'b1;
      repeat (12) @(negedge core_clk);
      verify(1'b1);
      for (int i = 0; i < 40; i++)
      begin
         seed = xorshift(seed);
         i_ctrl.levels(seed[3], 1'b1);
         if (i < 8)
            step(1'b1, i == 7, seed[0]);
         else
            step(seed[2:1] != 2'h2, seed[2], seed[0]);
         verify(seed[3]);
      end
      i_ctrl.levels(1'b0, 1'b0);
      step(1'b1, 1'b0, 1'b1);
      stages = 8'h00;
      verify(1'b0);
      i_ctrl.levels(1'b0, 1'b1);
      step(1'b0, 1'b1, 1'b0);
      verify(1'b0);
      finish_test();
   end
endmodule
`default_nettype wire

/* sipo_latch.sv */
// serial-in shift register feeding a three-state storage register
`timescale 1ns/100ps
`default_nettype none
module sipo_latch
(
   // clock and reset
   input wire logic i_core_clk,
   input wire logic i_reset_n,
   // controller pins
   input wire sipo_latch_pkg::ctrl_pins_t i_pins,
   // parallel outputs, data and enable per pin
   output logic [7:0] o_par_out,
   output logic [7:0] o_par_out_oe_n,
   // cascade output
   output logic o_cascade_out
);
   import sipo_latch_pkg::*;

   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic [4:0] pin_raw;
   logic [4:0] pin_lvl;
   logic serial_lvl;
   logic shift_lvl;
   logic store_lvl;
   logic clear_n_lvl;
   logic oe_n_lvl;
   logic shift_prev_reg;
   logic shift_prev_next;
   logic store_prev_reg;
   logic store_prev_next;
   logic [7:0] stages_reg;
   logic [7:0] stages_next;
   logic [7:0] store_reg;
   logic [7:0] store_next;
   logic [7:0] par_out_reg;
   logic [7:0] par_out_next;
   logic [7:0] oe_n_reg;
   logic [7:0] oe_n_next;
   logic cascade_reg;
   logic cascade_next;
   logic shift_rise;
   logic store_rise;

   // reset release
   always_ff @(posedge i_core_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         rst_sync_reg <= 2'h0;
      end
      else
      begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   assign pin_raw = i_pins;

   genvar g;
   generate
      for (g = 0; g < 5; g++)
      begin : g_sync
         // start at idle level, no false clear or enable
         pin_sync #(.INIT_LEVEL(PIN_IDLE[g])) u_sync
         (
            .i_core_clk(i_core_clk),
            .i_rst_n(rst_n),
            .i_pin(pin_raw[g]),
            .o_level(pin_lvl[g])
         );
      end
   endgenerate

   assign oe_n_lvl = pin_lvl[0];
   assign clear_n_lvl = pin_lvl[1];
   assign store_lvl = pin_lvl[2];
   assign shift_lvl = pin_lvl[3];
   assign serial_lvl = pin_lvl[4];

   assign shift_rise = shift_lvl & ~shift_prev_reg;
   assign store_rise = store_lvl & ~store_prev_reg;

   always_comb
   begin
      shift_prev_next = shift_lvl;
      store_prev_next = store_lvl;
      stages_next = stages_reg;
      store_next = store_reg;
      if (!clear_n_lvl)
      begin
         stages_next = STAGES_RESET;
      end
      else if (shift_rise)
      begin
         stages_next = {stages_reg[LAST_STAGE - 1:0], serial_lvl};
      end
      if (store_rise)
      begin
         store_next = stages_reg;
      end
      par_out_next = store_next;
      oe_n_next = oe_n_lvl ? OE_RELEASE : OE_DRIVE;
      cascade_next = stages_next[LAST_STAGE];
   end

   always_ff @(posedge i_core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         shift_prev_reg <= 1'b0;
         store_prev_reg <= 1'b0;
         stages_reg <= STAGES_RESET;
         store_reg <= STORE_RESET;
         par_out_reg <= STORE_RESET;
         oe_n_reg <= OE_RELEASE;
         cascade_reg <= 1'b0;
      end
      else
      begin
         shift_prev_reg <= shift_prev_next;
         store_prev_reg <= store_prev_next;
         stages_reg <= stages_next;
         store_reg <= store_next;
         par_out_reg <= par_out_next;
         oe_n_reg <= oe_n_next;
         cascade_reg <= cascade_next;
      end
   end

   assign o_par_out = par_out_reg;
   assign o_par_out_oe_n = oe_n_reg;
   assign o_cascade_out = cascade_reg;

   property p_shift;
      @(posedge i_core_clk) disable iff (!rst_n)
      (shift_rise && clear_n_lvl) |=> stages_reg == {$past(stages_reg[6:0]), $past(serial_lvl)};
   endproperty
   a_shift: assert property (p_shift) else $error("shift wrong");

   property p_clear;
      @(posedge i_core_clk) disable iff (!rst_n)
      !clear_n_lvl |=> stages_reg == 8'h00 && o_cascade_out == 1'b0;
   endproperty
   a_clear: assert property (p_clear) else $error("clear failed");

   property p_store;
      @(posedge i_core_clk) disable iff (!rst_n)
      store_rise |=> store_reg == $past(stages_reg);
   endproperty
   a_store: assert property (p_store) else $error("store wrong");

   property p_hold;
      @(posedge i_core_clk) disable iff (!rst_n)
      !store_rise |=> $stable(store_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("storage moved");

   property p_no_fall;
      @(posedge i_core_clk) disable iff (!rst_n)
      (clear_n_lvl && !shift_rise) |=> $stable(stages_reg);
   endproperty
   a_no_fall: assert property (p_no_fall) else $error("shift without edge");

   property p_disable;
      @(posedge i_core_clk) disable iff (!rst_n)
      oe_n_lvl |=> o_par_out_oe_n == 8'hFF;
   endproperty
   a_disable: assert property (p_disable) else $error("outputs not released");

   property p_enable;
      @(posedge i_core_clk) disable iff (!rst_n)
      !oe_n_lvl |=> o_par_out_oe_n == 8'h00 && o_par_out == store_reg;
   endproperty
   a_enable: assert property (p_enable) else $error("outputs not driven");

   property p_tied;
      @(posedge i_core_clk) disable iff (!rst_n)
      (shift_rise && store_rise && clear_n_lvl) |=>
         store_reg == $past(stages_reg) &&
         stages_reg == {$past(stages_reg[6:0]), $past(serial_lvl)};
   endproperty
   a_tied: assert property (p_tied) else $error("storage not lagging");

   property p_cascade;
      @(posedge i_core_clk) disable iff (!rst_n)
      1'b1 |=> o_cascade_out == stages_reg[7];
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade mismatch");

   c_shift: cover property (@(posedge i_core_clk) disable iff (!rst_n) shift_rise && clear_n_lvl);
   c_store: cover property (@(posedge i_core_clk) disable iff (!rst_n) store_rise);
   c_tied: cover property (@(posedge i_core_clk) disable iff (!rst_n) shift_rise && store_rise);
   c_clear: cover property (@(posedge i_core_clk) disable iff (!rst_n) !clear_n_lvl);
endmodule
`default_nettype wire

/* sipo_latch_pkg.sv */
// shared constants and carrier type for the serial-in parallel-out latch
package sipo_latch_pkg;
   localparam int unsigned WIDTH = 8;
   localparam int unsigned LAST_STAGE = 7;
   localparam logic [7:0] STAGES_RESET = 8'h00;
   localparam logic [7:0] STORE_RESET = 8'h00;
   localparam logic [7:0] OE_DRIVE = 8'h00;
   localparam logic [7:0] OE_RELEASE = 8'hFF;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   // pin idle levels: clocks low, clear and enable inactive high
   localparam logic [4:0] PIN_IDLE = 5'h03;

   typedef struct packed {
      logic serial_in;
      logic shift_clock;
      logic store_clock;
      logic shift_clear_n;
      logic out_enable_n;
   } ctrl_pins_t;
endpackage
